// *** cgc_top.sv ***
// Clock gating control with its AHB-Lite register slave and status flags.
`timescale 1ns/1ns
module cgc_top #(
    parameter logic [31:0] PER_IMPL_MASK = cgc_pkg::PER_IMPL_DEFAULT,
    parameter int LOCK_CYCLES = cgc_pkg::PLL_LOCK_CYCLES,
    parameter int SETTLE_CYCLES = cgc_pkg::MCK_SETTLE_CYCLES
) (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic clk_en,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    input wire logic proc_wake,
    output logic [31:0] hrdata,
    output logic hreadyout,
    output logic hresp,
    output logic processor_clock_bit,
    output logic usb_port_clock_48m,
    output logic [3:0] prog_clock_output_bit,
    output logic [31:0] peripheral_clock_bit,
    output logic [4:0] master_clock_config,
    output logic irq
);
    if (LOCK_CYCLES < 1 || LOCK_CYCLES > 255)
        $error("LOCK_CYCLES must be 1 to 255");
    if (SETTLE_CYCLES < 1 || SETTLE_CYCLES > 255)
        $error("SETTLE_CYCLES must be 1 to 255");

    function automatic logic hit(input logic [6:0] a, input logic [6:0] off);
        hit = (a[6:2] == off[6:2]);
    endfunction : hit

    cgc_pkg::cgc_bus_state_t bus_state_reg;
    cgc_pkg::cgc_bus_state_t bus_state_next;
    cgc_pkg::cgc_aphase_t aph_reg;
    logic [31:0] rdata_reg;
    logic hreadyout_reg;
    logic [31:0] sys_state;
    logic [31:0] per_state;
    logic [31:0] irq_mask;
    logic [31:0] osc_ctrl_reg;
    logic [31:0] pll_ctrl_reg;
    logic [31:0] mck_sel_reg;
    logic [31:0] pck0_cfg_reg;
    logic [31:0] pck1_cfg_reg;
    logic osc_stable_reg;
    logic pll_lock_reg;
    logic mck_ready_reg;
    logic [2:0] pck_ready_reg;
    logic [7:0] lock_cnt_reg;
    logic [7:0] settle_cnt_reg;
    logic irq_reg;

    // Address phase and data phase decode.
    wire logic addr_take = clk_en & hsel & hready & htrans[1];
    wire logic wr_phase = clk_en & (bus_state_reg == cgc_pkg::CGC_BUS_WR);
    wire logic wr_sys_en = wr_phase & hit(aph_reg.addr, cgc_pkg::OFF_SYS_EN);
    wire logic wr_sys_dis = wr_phase & hit(aph_reg.addr, cgc_pkg::OFF_SYS_DIS);
    wire logic wr_per_en = wr_phase & hit(aph_reg.addr, cgc_pkg::OFF_PER_EN);
    wire logic wr_per_dis = wr_phase & hit(aph_reg.addr, cgc_pkg::OFF_PER_DIS);
    wire logic wr_osc = wr_phase & hit(aph_reg.addr, cgc_pkg::OFF_OSC_CTRL);
    wire logic wr_pll = wr_phase & hit(aph_reg.addr, cgc_pkg::OFF_PLL_CTRL);
    wire logic wr_mck = wr_phase & hit(aph_reg.addr, cgc_pkg::OFF_MCK_SEL);
    wire logic wr_pck0 = wr_phase & hit(aph_reg.addr, cgc_pkg::OFF_PCK0_CFG);
    wire logic wr_pck1 = wr_phase & hit(aph_reg.addr, cgc_pkg::OFF_PCK1_CFG);
    wire logic wr_irq_en = wr_phase & hit(aph_reg.addr, cgc_pkg::OFF_IRQ_EN);
    wire logic wr_irq_dis = wr_phase & hit(aph_reg.addr, cgc_pkg::OFF_IRQ_DIS);

    // Set and clear vectors; zero bits leave every enable as it was.
    wire logic [31:0] sys_set = {31'h00000000, proc_wake}
        | (wr_sys_en ? (hwdata & cgc_pkg::SYS_EN_MASK) : 32'h00000000);
    wire logic [31:0] sys_clr =
        wr_sys_dis ? (hwdata & cgc_pkg::SYS_DIS_MASK) : 32'h00000000;
    wire logic [31:0] per_set = wr_per_en ? hwdata : 32'h00000000;
    wire logic [31:0] per_clr = wr_per_dis ? hwdata : 32'h00000000;
    wire logic [31:0] irq_set = wr_irq_en ? hwdata : 32'h00000000;
    wire logic [31:0] irq_clr = wr_irq_dis ? hwdata : 32'h00000000;

    cgc_setclr #(
        .W(32),
        .RESET_VAL(cgc_pkg::SYS_STATE_RESET),
        .IMPL_MASK(cgc_pkg::SYS_DIS_MASK)
    ) u_sys (
        .hclk(hclk),
        .hresetn(hresetn),
        .ce(clk_en),
        .set_bits(sys_set),
        .clr_bits(sys_clr),
        .state_reg(sys_state)
    );

    // Unbuilt peripheral bits are masked off inside the register.
    cgc_setclr #(
        .W(32),
        .RESET_VAL(cgc_pkg::PER_STATE_RESET),
        .IMPL_MASK(PER_IMPL_MASK)
    ) u_per (
        .hclk(hclk),
        .hresetn(hresetn),
        .ce(clk_en),
        .set_bits(per_set),
        .clr_bits(per_clr),
        .state_reg(per_state)
    );

    cgc_setclr #(
        .W(32),
        .RESET_VAL(cgc_pkg::IRQ_MASK_RESET),
        .IMPL_MASK(cgc_pkg::IRQ_MASK_IMPL)
    ) u_imr (
        .hclk(hclk),
        .hresetn(hresetn),
        .ce(clk_en),
        .set_bits(irq_set),
        .clr_bits(irq_clr),
        .state_reg(irq_mask)
    );

    // Configuration registers; all but the two programmable clock ones steer the ready flags.
    wire logic [31:0] mck_wdata = hwdata & cgc_pkg::CFG_SEL_MASK;
    wire logic mck_change = wr_mck & (mck_wdata != mck_sel_reg);
    wire logic mck_on_pll = mck_sel_reg[1:0] == cgc_pkg::CLOCK_SOURCE_PLL;
    wire logic mck_drop = mck_change | (wr_pll & mck_on_pll);

    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            osc_ctrl_reg <= cgc_pkg::OSC_CTRL_RESET;
            pll_ctrl_reg <= cgc_pkg::PLL_CTRL_RESET;
            mck_sel_reg <= cgc_pkg::MCK_SEL_RESET;
            pck0_cfg_reg <= cgc_pkg::PCK_CFG_RESET;
            pck1_cfg_reg <= cgc_pkg::PCK_CFG_RESET;
        end
        else if (clk_en)
        begin
            if (wr_osc)
                osc_ctrl_reg <= hwdata & cgc_pkg::OSC_CTRL_MASK;
            if (wr_pll)
                pll_ctrl_reg <= hwdata & cgc_pkg::PLL_CTRL_MASK;
            if (wr_mck)
                mck_sel_reg <= mck_wdata;
            if (wr_pck0)
                pck0_cfg_reg <= hwdata & cgc_pkg::CFG_SEL_MASK;
            if (wr_pck1)
                pck1_cfg_reg <= hwdata & cgc_pkg::CFG_SEL_MASK;
        end
    end

    // The PLL lock flag falls on every PLL write and rises after a fixed count.
    wire logic lock_done = (lock_cnt_reg == 8'h01);
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            lock_cnt_reg <= 8'h00;
            pll_lock_reg <= 1'b0;
        end
        else if (clk_en)
        begin
            if (wr_pll)
            begin
                lock_cnt_reg <= 8'(LOCK_CYCLES);
                pll_lock_reg <= 1'b0;
            end
            else if (lock_cnt_reg != 8'h00)
            begin
                lock_cnt_reg <= lock_cnt_reg - 8'h01;
                pll_lock_reg <= lock_done;
            end
        end
    end

    // A settling count restarts on each change; on the PLL source it also waits for lock.
    wire logic settle_done = (settle_cnt_reg == 8'h00) & (!mck_on_pll | pll_lock_reg);
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            settle_cnt_reg <= 8'h00;
            mck_ready_reg <= cgc_pkg::STATUS_RESET[cgc_pkg::MASTER_CLOCK_READY_FLAG];
        end
        else if (clk_en)
        begin
            if (mck_drop)
            begin
                settle_cnt_reg <= 8'(SETTLE_CYCLES);
                mck_ready_reg <= 1'b0;
            end
            else
            begin
                if (settle_cnt_reg != 8'h00)
                    settle_cnt_reg <= settle_cnt_reg - 8'h01;
                if (settle_done)
                    mck_ready_reg <= 1'b1;
            end
        end
    end

    // Oscillator is stable while enabled or bypassed, and clears when both are off.
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
            osc_stable_reg <= 1'b0;
        else if (clk_en)
            osc_stable_reg <= osc_ctrl_reg[0] | osc_ctrl_reg[1];
    end

    // Programmable clocks 0 to 2 are reported ready one cycle after their outputs run; clock 3 has no ready flag.
    for (genvar i = 0; i < cgc_pkg::PROG_READY_FLAGS; i++)
    begin : g_pck_ready
        always_ff @(posedge hclk or negedge hresetn)
        begin
            if (!hresetn)
                pck_ready_reg[i] <= 1'b0;
            else if (clk_en)
                pck_ready_reg[i] <= sys_state[cgc_pkg::PROG_CLOCK_OUTPUT_BIT + i];
        end
    end

    wire logic [31:0] status_word = {21'h000000, pck_ready_reg, 4'h0,
        mck_ready_reg, pll_lock_reg, 1'b0, osc_stable_reg};
    wire logic irq_next = |(status_word & irq_mask);

    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
            irq_reg <= 1'b0;
        else if (clk_en)
            irq_reg <= irq_next;
    end

    // Read selection; reserved and write-only offsets read as zero.
    wire logic [6:0] ra = aph_reg.addr;
    wire logic [31:0] rdata_sel =
        hit(ra, cgc_pkg::OFF_SYS_STATE) ? sys_state :
        hit(ra, cgc_pkg::OFF_PER_STATE) ? per_state :
        hit(ra, cgc_pkg::OFF_OSC_CTRL) ? osc_ctrl_reg :
        hit(ra, cgc_pkg::OFF_PLL_CTRL) ? pll_ctrl_reg :
        hit(ra, cgc_pkg::OFF_MCK_SEL) ? mck_sel_reg :
        hit(ra, cgc_pkg::OFF_PCK0_CFG) ? pck0_cfg_reg :
        hit(ra, cgc_pkg::OFF_PCK1_CFG) ? pck1_cfg_reg :
        hit(ra, cgc_pkg::OFF_STATUS) ? status_word :
        hit(ra, cgc_pkg::OFF_IRQ_MASK) ? irq_mask : 32'h00000000;

    // Reads take one wait state so that a write just before is always visible.
    always_comb
    begin
        bus_state_next = bus_state_reg;
        case (bus_state_reg)
            cgc_pkg::CGC_BUS_RD:
                bus_state_next = cgc_pkg::CGC_BUS_RDOUT;
            cgc_pkg::CGC_BUS_IDLE, cgc_pkg::CGC_BUS_WR, cgc_pkg::CGC_BUS_RDOUT:
                if (addr_take)
                    bus_state_next = hwrite ? cgc_pkg::CGC_BUS_WR : cgc_pkg::CGC_BUS_RD;
                else
                    bus_state_next = cgc_pkg::CGC_BUS_IDLE;
            default:
                bus_state_next = cgc_pkg::CGC_BUS_IDLE;
        endcase
    end

    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            bus_state_reg <= cgc_pkg::CGC_BUS_IDLE;
            aph_reg <= '0;
            rdata_reg <= 32'h00000000;
            hreadyout_reg <= 1'b1;
        end
        else if (clk_en)
        begin
            bus_state_reg <= bus_state_next;
            if (addr_take)
                aph_reg <= '{wr: hwrite, addr: haddr[6:0]};
            if (bus_state_reg == cgc_pkg::CGC_BUS_RD)
                rdata_reg <= rdata_sel;
            hreadyout_reg <= (bus_state_next != cgc_pkg::CGC_BUS_RD);
        end
    end

    assign hrdata = rdata_reg;
    assign hreadyout = hreadyout_reg;
    assign hresp = 1'b0;
    assign processor_clock_bit = sys_state[cgc_pkg::PROCESSOR_CLOCK_BIT];
    assign usb_port_clock_48m = sys_state[cgc_pkg::USB_PORT_CLOCK_BIT];
    assign prog_clock_output_bit = sys_state[cgc_pkg::PROG_CLOCK_OUTPUT_BIT +: 4];
    assign peripheral_clock_bit = per_state;
    assign master_clock_config = mck_sel_reg[4:0];
    assign irq = irq_reg;

    usb_on_a: assert property (@(posedge hclk) disable iff (!hresetn)
        wr_sys_en && hwdata[7] |=> usb_port_clock_48m)
        else $error("USB clock not started by enable write");

    prog_on_a: assert property (@(posedge hclk) disable iff (!hresetn)
        wr_sys_en |=> (prog_clock_output_bit & $past(hwdata[11:8])) == $past(hwdata[11:8]))
        else $error("Programmable output not started by enable write");

    proc_idle_a: assert property (@(posedge hclk) disable iff (!hresetn)
        wr_sys_dis && hwdata[0] && !proc_wake |=> !processor_clock_bit)
        else $error("Processor clock not stopped by disable write");

    usb_off_a: assert property (@(posedge hclk) disable iff (!hresetn)
        wr_sys_dis && hwdata[7] |=> !usb_port_clock_48m)
        else $error("USB clock not stopped by disable write");

    prog_off_a: assert property (@(posedge hclk) disable iff (!hresetn)
        wr_sys_dis |=> (prog_clock_output_bit & $past(hwdata[11:8])) == 4'h0)
        else $error("Programmable output not stopped by disable write");

    sys_read_a: assert property (@(posedge hclk) disable iff (!hresetn)
        clk_en && bus_state_reg == cgc_pkg::CGC_BUS_RD && hit(ra, cgc_pkg::OFF_SYS_STATE)
        |=> hreadyout && hrdata == {20'h00000, prog_clock_output_bit, usb_port_clock_48m,
            6'h00, processor_clock_bit})
        else $error("System clock state read does not match enables");

    per_on_a: assert property (@(posedge hclk) disable iff (!hresetn)
        wr_per_en |=> (peripheral_clock_bit & $past(hwdata) & PER_IMPL_MASK)
            == ($past(hwdata) & PER_IMPL_MASK))
        else $error("Peripheral clock not started by enable write");

    per_off_a: assert property (@(posedge hclk) disable iff (!hresetn)
        wr_per_dis |=> (peripheral_clock_bit & $past(hwdata)) == 32'h00000000)
        else $error("Peripheral clock not stopped by disable write");

    per_unbuilt_a: assert property (@(posedge hclk) disable iff (!hresetn)
        (peripheral_clock_bit & ~PER_IMPL_MASK) == 32'h00000000)
        else $error("Unbuilt peripheral clock became enabled");

    mck_drop_a: assert property (@(posedge hclk) disable iff (!hresetn)
        mck_change |=> !mck_ready_reg [*2])
        else $error("Master ready did not drop on a selection change");

    irq_track_a: assert property (@(posedge hclk) disable iff (!hresetn)
        clk_en |=> irq == $past(irq_next))
        else $error("Interrupt output does not follow masked flags");

    mask_set_a: assert property (@(posedge hclk) disable iff (!hresetn)
        wr_irq_en |=> (irq_mask & $past(hwdata) & cgc_pkg::IRQ_MASK_IMPL)
            == ($past(hwdata) & cgc_pkg::IRQ_MASK_IMPL))
        else $error("Interrupt enable write did not unmask");

    idle_cover_c: cover property (@(posedge hclk) disable iff (!hresetn)
        wr_sys_dis && hwdata[0] ##1 !processor_clock_bit);
    per_cover_c: cover property (@(posedge hclk) disable iff (!hresetn)
        wr_per_en ##[1:20] wr_per_dis);
    mck_cover_c: cover property (@(posedge hclk) disable iff (!hresetn)
        mck_change ##[1:300] mck_ready_reg);
    irq_cover_c: cover property (@(posedge hclk) disable iff (!hresetn)
        $rose(irq));

endmodule : cgc_top

// *** cgc_pkg.sv ***
// Shared constants and types of the clock gating control block.
// Behaviour
// - Writing one to the USB bit of clock enable starts the 48 MHz USB clock.
// - Writing one to enable bits 8 to 11 starts that programmable clock output.
// - Writing one to disable bit 0 stops the processor clock for idle mode.
// - Writing one to disable bit 7 stops the 48 MHz USB clock.
// - Writing one to a programmable output disable bit stops that output.
// - System clock state reads the live enables and resets to 0x01.
// - State bit 0 is one while the processor clock runs, else zero.
// - State bit 7 is one while the USB clock runs, else zero.
// - Each programmable output state bit follows its enable and disable writes.
// - Writing one to peripheral enable bits 2 to 31 starts that peripheral clock.
// - Bits for peripherals that are not built change nothing.
// - Writing one to a peripheral disable bit stops that peripheral clock.
// - Peripheral state shows running clocks in bits 2 to 31, resets to zero.
// - Writing one to an interrupt enable bit unmasks that status flag.
// - Master ready drops on source or prescaler change, sets when clocks settle.
package cgc_pkg;

    localparam int ADDR_W = 7;

    localparam logic [6:0] OFF_SYS_EN = 7'h00;
    localparam logic [6:0] OFF_SYS_DIS = 7'h04;
    localparam logic [6:0] OFF_SYS_STATE = 7'h08;
    localparam logic [6:0] OFF_PER_EN = 7'h10;
    localparam logic [6:0] OFF_PER_DIS = 7'h14;
    localparam logic [6:0] OFF_PER_STATE = 7'h18;
    localparam logic [6:0] OFF_OSC_CTRL = 7'h20;
    localparam logic [6:0] OFF_MCK_FREQ = 7'h24;
    localparam logic [6:0] OFF_PLL_CTRL = 7'h2C;
    localparam logic [6:0] OFF_MCK_SEL = 7'h30;
    localparam logic [6:0] OFF_PCK0_CFG = 7'h40;
    localparam logic [6:0] OFF_PCK1_CFG = 7'h44;
    localparam logic [6:0] OFF_IRQ_EN = 7'h60;
    localparam logic [6:0] OFF_IRQ_DIS = 7'h64;
    localparam logic [6:0] OFF_STATUS = 7'h68;
    localparam logic [6:0] OFF_IRQ_MASK = 7'h6C;

    // System clock bit positions.
    localparam int PROCESSOR_CLOCK_BIT = 0;
    localparam int USB_PORT_CLOCK_BIT = 7;
    localparam int PROG_CLOCK_OUTPUT_BIT = 8;
    localparam int PROG_CLOCKS = 4;
    localparam logic [31:0] SYS_EN_MASK = 32'h00000F80;
    localparam logic [31:0] SYS_DIS_MASK = 32'h00000F81;
    localparam logic [31:0] SYS_STATE_RESET = 32'h00000001;

    localparam logic [31:0] PER_IMPL_DEFAULT = 32'hFFFFFFFC;
    localparam logic [31:0] PER_STATE_RESET = 32'h00000000;

    // Status flag positions and reset values.
    localparam int OSCILLATOR_STABLE_FLAG = 0;
    localparam int PLL_LOCK_FLAG = 2;
    localparam int MASTER_CLOCK_READY_FLAG = 3;
    localparam int PROG_CLOCK_READY_FLAG = 8;
    localparam int PROG_READY_FLAGS = 3;
    localparam logic [31:0] STATUS_RESET = 32'h00000008;
    localparam logic [31:0] IRQ_MASK_IMPL = 32'h0000070D;
    localparam logic [31:0] IRQ_MASK_RESET = 32'h00000000;

    localparam logic [31:0] OSC_CTRL_RESET = 32'h00000000;
    localparam logic [31:0] OSC_CTRL_MASK = 32'h0000FF03;
    localparam logic [31:0] PLL_CTRL_RESET = 32'h00003F00;
    localparam logic [31:0] PLL_CTRL_MASK = 32'h37FFFFFF;
    localparam logic [31:0] MCK_SEL_RESET = 32'h00000000;
    localparam logic [31:0] CFG_SEL_MASK = 32'h0000001F;
    localparam logic [31:0] PCK_CFG_RESET = 32'h00000000;
    localparam logic [1:0] CLOCK_SOURCE_PLL = 2'h3;

    // Settling counts in clock cycles.
    localparam int PLL_LOCK_CYCLES = 8;
    localparam int MCK_SETTLE_CYCLES = 64;

    typedef enum logic [3:0] {
        CGC_BUS_IDLE = 4'b0001,
        CGC_BUS_WR = 4'b0010,
        CGC_BUS_RD = 4'b0100,
        CGC_BUS_RDOUT = 4'b1000
    } cgc_bus_state_t;

    typedef struct packed {
        logic wr;
        logic [6:0] addr;
    } cgc_aphase_t;

endpackage : cgc_pkg

// *** cgc_setclr.sv ***
// One register of clock enables driven by write-one set and clear vectors.
`timescale 1ns/1ns
module cgc_setclr #(
    parameter int W = 32,
    parameter logic [31:0] RESET_VAL = 32'h00000000,
    parameter logic [31:0] IMPL_MASK = 32'hFFFFFFFF
) (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic ce,
    input wire logic [W-1:0] set_bits,
    input wire logic [W-1:0] clr_bits,
    output logic [W-1:0] state_reg
);
    logic [W-1:0] state_next;

    if (W < 1 || W > 32)
        $error("cgc_setclr width must be 1 to 32");

    // A set in the same cycle as a clear wins, so a wake event is not lost to a disable write.
    assign state_next = ((state_reg & ~clr_bits) | set_bits) & IMPL_MASK[W-1:0];

    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
            state_reg <= RESET_VAL[W-1:0];
        else if (ce)
            state_reg <= state_next;
    end

endmodule : cgc_setclr

// *** cgc_top_tb.sv ***
// Self-checking testbench of the clock gating control block.
`timescale 1ns/1ns
module cgc_top_tb;
    // Only bits 2 to 15 are built, so writes to bits 16 to 31 must change nothing.
    localparam logic [31:0] IMPL = 32'h0000FFFC;
    logic hclk;
    logic hresetn;
    logic clk_en;
    logic hsel;
    logic [31:0] haddr;
    logic [1:0] htrans;
    logic hwrite;
    logic [2:0] hsize;
    logic [31:0] hwdata;
    logic proc_wake;
    logic [31:0] hrdata;
    logic hreadyout;
    logic hresp;
    logic processor_clock_bit;
    logic usb_port_clock_48m;
    logic [3:0] prog_clock_output_bit;
    logic [31:0] peripheral_clock_bit;
    logic [4:0] master_clock_config;
    logic irq;
    int fails;
    int num_checks;

    cgc_top #(.PER_IMPL_MASK(IMPL), .LOCK_CYCLES(2), .SETTLE_CYCLES(4)) u_cgc_top (
        .hclk(hclk), .hresetn(hresetn), .clk_en(clk_en), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
        .hready(hreadyout), .proc_wake(proc_wake), .hrdata(hrdata),
        .hreadyout(hreadyout), .hresp(hresp), .processor_clock_bit(processor_clock_bit),
        .usb_port_clock_48m(usb_port_clock_48m), .prog_clock_output_bit(prog_clock_output_bit),
        .peripheral_clock_bit(peripheral_clock_bit), .master_clock_config(master_clock_config),
        .irq(irq)
    );

    task automatic check(input logic [31:0] got, input logic [31:0] exp, input string what);
        num_checks++;
        if (got !== exp)
        begin
            fails++;
            $display("CHECK FAILED at %0t: %s got %h expected %h", $time, what, got, exp);
        end
    endtask : check

    // The master never assumes a latency; it waits for hready under a bound.
    task automatic wait_ready();
        int n;
        n = 0;
        do
        begin
            @(posedge hclk);
            n++;
        end
        while (hreadyout !== 1'b1 && n < 20);
        if (n >= 20)
        begin
            fails++;
            $display("CHECK FAILED at %0t: bus never ready", $time);
        end
    endtask : wait_ready

    task automatic bus(input logic wr_n, input logic [6:0] addr, input logic [31:0] wd,
                       output logic [31:0] rdv);
        hsel <= 1'b1;
        htrans <= 2'h2;
        haddr <= {25'h0000000, addr};
        hwrite <= wr_n;
        hsize <= 3'h2;
        wait_ready();
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= wd;
        wait_ready();
        rdv = hrdata;
    endtask : bus

    task automatic wr(input logic [6:0] addr, input logic [31:0] wd);
        logic [31:0] dummy;
        bus(1'b1, addr, wd, dummy);
        #1;
    endtask : wr

    task automatic rdc(input logic [6:0] addr, input logic [31:0] exp, input string what);
        logic [31:0] v;
        bus(1'b0, addr, 32'h00000000, v);
        check(v, exp, what);
        check({31'h00000000, hresp}, 32'h00000000, "hresp");
    endtask : rdc

    task automatic t_reset();
        #1;
        check({31'h00000000, processor_clock_bit}, 32'h00000001, "cpu clock");
        check({27'h0000000, master_clock_config}, 32'h00000000, "mck config");
        rdc(cgc_pkg::OFF_SYS_STATE, 32'h00000001, "sys state");
        rdc(cgc_pkg::OFF_PER_STATE, 32'h00000000, "per state");
        rdc(cgc_pkg::OFF_STATUS, 32'h00000008, "status");
        rdc(cgc_pkg::OFF_IRQ_MASK, 32'h00000000, "mask");
        rdc(cgc_pkg::OFF_PLL_CTRL, 32'h00003F00, "pll ctrl");
        rdc(7'h0C, 32'h00000000, "reserved");
        wr(cgc_pkg::OFF_SYS_STATE, 32'hFFFFFFFF);
        rdc(cgc_pkg::OFF_SYS_STATE, 32'h00000001, "read-only state");
        $display("test reset done");
    endtask : t_reset

    task automatic t_sys();
        for (int i = 0; i < 4; i++)
        begin
            wr(cgc_pkg::OFF_SYS_EN, 32'h00000100 << i);
            check({28'h0000000, prog_clock_output_bit}, 32'h00000001 << i, "prog on");
            rdc(cgc_pkg::OFF_SYS_STATE, (32'h00000100 << i) | 32'h00000001, "state on");
            wr(cgc_pkg::OFF_SYS_DIS, 32'h00000100 << i);
            check({28'h0000000, prog_clock_output_bit}, 32'h00000000, "prog off");
        end
        wr(cgc_pkg::OFF_SYS_EN, 32'hFFFFFFFF);
        check({31'h00000000, usb_port_clock_48m}, 32'h00000001, "usb on");
        wr(cgc_pkg::OFF_SYS_EN, 32'h00000000);
        rdc(cgc_pkg::OFF_SYS_STATE, 32'h00000F81, "state all");
        wr(cgc_pkg::OFF_SYS_DIS, 32'h00000280);
        check({31'h00000000, usb_port_clock_48m}, 32'h00000000, "usb off");
        check({28'h0000000, prog_clock_output_bit}, 32'h0000000D, "prog mix");
        rdc(cgc_pkg::OFF_SYS_STATE, 32'h00000D01, "state mix");
        wr(cgc_pkg::OFF_SYS_DIS, 32'h00000D00);
        $display("test system clocks done");
    endtask : t_sys

    task automatic t_cpu();
        wr(cgc_pkg::OFF_SYS_DIS, 32'h00000001);
        check({31'h00000000, processor_clock_bit}, 32'h00000000, "cpu idle");
        wr(cgc_pkg::OFF_SYS_DIS, 32'h00000000);
        rdc(cgc_pkg::OFF_SYS_STATE, 32'h00000000, "state idle");
        // A wake pulse seen only while the clock enable is low must be lost.
        @(posedge hclk);
        clk_en <= 1'b0;
        proc_wake <= 1'b1;
        @(posedge hclk);
        proc_wake <= 1'b0;
        @(posedge hclk);
        clk_en <= 1'b1;
        #1;
        check({31'h00000000, processor_clock_bit}, 32'h00000000, "frozen wake");
        @(posedge hclk);
        proc_wake <= 1'b1;
        @(posedge hclk);
        proc_wake <= 1'b0;
        rdc(cgc_pkg::OFF_SYS_STATE, 32'h00000001, "state wake");
        $display("test processor idle done");
    endtask : t_cpu

    task automatic t_per();
        wr(cgc_pkg::OFF_PER_EN, 32'hFFFFFFFF);
        check(peripheral_clock_bit, 32'h0000FFFC, "per on");
        rdc(cgc_pkg::OFF_PER_STATE, 32'h0000FFFC, "per state on");
        wr(cgc_pkg::OFF_PER_DIS, 32'h00000110);
        check(peripheral_clock_bit, 32'h0000FEEC, "per some off");
        wr(cgc_pkg::OFF_PER_EN, 32'h00000000);
        wr(cgc_pkg::OFF_PER_DIS, 32'h00000000);
        rdc(cgc_pkg::OFF_PER_STATE, 32'h0000FEEC, "per zero writes");
        wr(cgc_pkg::OFF_PER_DIS, 32'hFFFFFFFF);
        rdc(cgc_pkg::OFF_PER_STATE, 32'h00000000, "per all off");
        $display("test peripheral clocks done");
    endtask : t_per

    task automatic t_irq();
        int n;
        wr(cgc_pkg::OFF_IRQ_EN, 32'h00000008);
        rdc(cgc_pkg::OFF_IRQ_MASK, 32'h00000008, "mask set");
        check({31'h00000000, irq}, 32'h00000001, "irq ready");
        wr(cgc_pkg::OFF_MCK_SEL, 32'h00000001);
        repeat (2) @(posedge hclk);
        #1;
        check({31'h00000000, irq}, 32'h00000000, "irq drop");
        n = 0;
        while (irq !== 1'b1 && n < 50)
        begin
            @(posedge hclk);
            n++;
        end
        #1;
        check({31'h00000000, irq}, 32'h00000001, "irq back");
        check({27'h0000000, master_clock_config}, 32'h00000001, "mck config");
        rdc(cgc_pkg::OFF_STATUS, 32'h00000008, "status ready");
        wr(cgc_pkg::OFF_IRQ_DIS, 32'h00000008);
        rdc(cgc_pkg::OFF_IRQ_MASK, 32'h00000000, "mask clear");
        check({31'h00000000, irq}, 32'h00000000, "irq masked");
        // Lock follows a PLL write after the short count; the oscillator flag follows its enable.
        wr(cgc_pkg::OFF_PLL_CTRL, 32'h00021F03);
        wr(cgc_pkg::OFF_OSC_CTRL, 32'h00000001);
        rdc(cgc_pkg::OFF_STATUS, 32'h0000000D, "status lock");
        rdc(cgc_pkg::OFF_PLL_CTRL, 32'h00021F03, "pll ctrl back");
        $display("test interrupt done");
    endtask : t_irq

    task automatic complete_run();
        $display("checks %0d mismatches %0d", num_checks, fails);
        if (fails == 0 && num_checks > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask : complete_run

    initial
    begin
        hclk = 1'b0;
        forever #5 hclk = ~hclk;
    end

    initial
    begin
        fails = 0;
        num_checks = 0;
        hresetn = 1'b0;
        clk_en = 1'b1;
        hsel = 1'b0;
        haddr = 32'h00000000;
        htrans = 2'h0;
        hwrite = 1'b0;
        hsize = 3'h2;
        hwdata = 32'h00000000;
        proc_wake = 1'b0;
        repeat (8) @(posedge hclk);
        hresetn <= 1'b1;
        @(posedge hclk);
        t_reset();
        t_sys();
        t_cpu();
        t_per();
        t_irq();
        complete_run();
    end

    // The tests need under two thousand nanoseconds; this limit only catches a hang.
    initial
    begin
        #100000;
        fails++;
        $display("CHECK FAILED at %0t: watchdog expired", $time);
        complete_run();
    end
endmodule : cgc_top_tb
